/* File: logic/hfh_defines.svh */
`ifndef HFH_DEFINES_SVH
`define HFH_DEFINES_SVH
// Device register addresses on the host link
`define HFH_A_RXCNT  8'h00
`define HFH_A_RXFIFO 8'h01
`define HFH_A_RXRT   8'h02
`define HFH_A_RXLAT  8'h03
`define HFH_A_RXMSK  8'h04
`define HFH_A_RXWM   8'h05
`define HFH_A_TC1    8'h10
`define HFH_A_TBS    8'h11
`define HFH_A_TC2    8'h12
`define HFH_A_TXWM   8'h13
`define HFH_A_TXRT   8'h14
`define HFH_A_TXLAT  8'h15
`define HFH_A_TXMSK  8'h16
`define HFH_A_TXSPC  8'h17
`define HFH_A_TXFIFO 8'h18
// Field positions
`define HFH_RX_MEND  0
`define HFH_RX_HWM   1
`define HFH_RX_OVR   5
`define HFH_TX_MEND  0
`define HFH_TX_UDR   1
`define HFH_TX_LWM   2
`define HFH_TC1_EOM  2
`define HFH_TC1_RST  5
`define HFH_FIFO_FULL 7'h40
// Controller registers, AXI4-Lite byte addresses
`define HFH_R_CTRL   5'h00
`define HFH_R_TXCFG  5'h04
`define HFH_R_TXLEN  5'h08
`define HFH_R_TXDATA 5'h0c
`define HFH_R_RXDATA 5'h10
`define HFH_R_IST    5'h14
`define HFH_R_IMSK   5'h18
`define HFH_EV_TXDONE 0
`define HFH_EV_RESEND 1
`define HFH_EV_RXDONE 2
`define HFH_RESP_OKAY   2'b00
`define HFH_RESP_SLVERR 2'b10
`endif

/* File: logic/hfh_pkg.sv */
`default_nettype none
package hfh_pkg;
  typedef enum logic [3:0] {
    HFH_IDLE  = 4'b0000,
    HFH_CFG   = 4'b0001,
    HFH_TMASK = 4'b0010,
    HFH_TSPC  = 4'b0011,
    HFH_TSPW  = 4'b0100,
    HFH_TPUSH = 4'b0101,
    HFH_TWAIT = 4'b0110,
    HFH_TLATW = 4'b0111,
    HFH_TDEC  = 4'b1000,
    HFH_RCNT  = 4'b1001,
    HFH_RCNTW = 4'b1010,
    HFH_RBYTE = 4'b1011,
    HFH_RBYW  = 4'b1100,
    HFH_RSTW  = 4'b1101
  } hfh_state_type;

  typedef struct packed {
    logic [63:0][8:0] rxm;
    logic [5:0]       rxw;
    logic [5:0]       rxr;
    logic [6:0]       rxn;
    logic             rxdrop;
    logic [63:0][8:0] txm;
    logic [5:0]       txw;
    logic [5:0]       txr;
    logic [6:0]       txn;
    logic [7:0]       rlat;
    logic [7:0]       rmask;
    logic [7:0]       rwm;
    logic [7:0]       runrd;
    logic [7:0]       rrtq;
    logic [7:0]       tlat;
    logic [7:0]       tmask;
    logic [7:0]       twm;
    logic [7:0]       tunrd;
    logic [7:0]       trtq;
    logic [7:0]       ctl1;
    logic [7:0]       bsup;
    logic [7:0]       ctl2;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             irq_n;
    logic [7:0]       txb;
    logic             txl;
    logic             txv;
  } hfh_dev_type;

  typedef struct packed {
    hfh_state_type    st;
    logic [2:0]       sub;
    logic             awready;
    logic             wready;
    logic             arready;
    logic             awv;
    logic             wv;
    logic [4:0]       awa;
    logic [31:0]      wd;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             irq;
    logic [31:0]      cfg;
    logic [6:0]       len;
    logic [63:0][7:0] buff;
    logic [5:0]       bwp;
    logic [6:0]       idx;
    logic [6:0]       navail;
    logic [6:0]       rxleft;
    logic [7:0]       rxcnt;
    logic [7:0]       rxbyte;
    logic [7:0]       rxst;
    logic [7:0]       tst;
    logic [2:0]       ist;
    logic [2:0]       imsk;
    logic [7:0]       laddr;
    logic [7:0]       lwd;
    logic             lwr;
    logic             lrd;
  } hfh_host_type;
endpackage
`default_nettype wire

/* File: logic/hfh_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hfh_if;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq_out_n;
  modport dev (input addr, input wr, input rd, input wdata, output rdata, output rvalid, output irq_out_n);
  modport host (output addr, output wr, output rd, output wdata, input rdata, input rvalid, input irq_out_n);
endinterface
`default_nettype wire

/* File: logic/hfh_dev.sv */
// Behaviour
// - Receive count: low seven bits, 0..64
// - Count stops at one message boundary
// - Count top bit set while message unfinished
// - Host checks status unless continuation flagged
// - Latched bits stick until host clears
// - Write-one clears latched bits only
// - Real-time bits follow present condition
// - Every latched event individually maskable
// - Unmasked event drives interrupt low until read
// - Transmit free space reported live
// - Free space stable during a read
// - Host configures, then resets transmit path
// - Host writes at most free-space bytes
// - Host marks end before final byte
// - 64-byte FIFO each direction
// - Overrun drops packet, empties FIFO, flags
// - Watermark real-time bits on both FIFOs
`include "hfh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hfh_dev (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  hfh_if.dev              bus,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_last,
  output var  logic       tx_valid,
  output var  logic [7:0] tx_byte,
  output var  logic       tx_last,
  input  wire logic       tx_ready,
  output var  logic [7:0] tx_hdlc_ctrl_two,
  output var  logic [7:0] tx_bit_suppress
);
  hfh_pkg::hfh_dev_type s;
  hfh_pkg::hfh_dev_type n;

  // Bytes up to and including the first end marker; top bit when bytes are held but none is an end marker
  function automatic logic [7:0] hfh_seg(input logic [63:0][8:0] m, input logic [5:0] rd, input logic [6:0] cnt);
    logic [6:0] len;
    logic       fnd;
    logic [5:0] ix;
    len = 7'h00;
    fnd = 1'b0;
    ix  = rd;
    for (int i = 0; i < 64; i++) begin
      if (!fnd && 7'(i) < cnt) begin
        len = len + 7'h01;
        fnd = m[ix][8];
      end
      ix = ix + 6'h01;
    end
    return {~fnd & (len != 7'h00), len};
  endfunction

  always_comb begin
    logic [7:0] seg;
    logic [7:0] rrt;
    logic [7:0] trt;
    logic [7:0] rev;
    logic [7:0] tev;
    logic [7:0] rclr;
    logic [7:0] tclr;
    logic [7:0] rack;
    logic [7:0] tack;
    logic       push;
    logic       pop;
    logic       tpush;
    logic       tpop;
    logic       ovr;
    n     = s;
    seg   = hfh_seg(s.rxm, s.rxr, s.rxn);
    rrt   = 8'h00;
    trt   = 8'h00;
    rev   = 8'h00;
    tev   = 8'h00;
    rclr  = 8'h00;
    tclr  = 8'h00;
    rack  = 8'h00;
    tack  = 8'h00;
    push  = 1'b0;
    pop   = 1'b0;
    tpush = 1'b0;
    tpop  = 1'b0;
    ovr   = 1'b0;
    n.rvalid = 1'b0;
    rrt[0] = s.rxn != 7'h00;
    rrt[`HFH_RX_HWM] = s.rxn > s.rwm[6:0];
    rrt[`HFH_RX_OVR] = s.rxdrop;
    trt[`HFH_TX_LWM] = s.txn < s.twm[6:0];

    if (bus.rd) begin
      n.rvalid = 1'b1;
      if (bus.addr == `HFH_A_RXCNT) begin
        n.rdata = seg;
      end else if (bus.addr == `HFH_A_RXFIFO) begin
        n.rdata = s.rxm[s.rxr][7:0];
        pop = s.rxn != 7'h00;
      end else if (bus.addr == `HFH_A_RXRT) begin
        n.rdata = rrt;
      end else if (bus.addr == `HFH_A_RXLAT) begin
        n.rdata = s.rlat;
        rack = 8'hff;
      end else if (bus.addr == `HFH_A_RXMSK) begin
        n.rdata = s.rmask;
      end else if (bus.addr == `HFH_A_RXWM) begin
        n.rdata = s.rwm;
      end else if (bus.addr == `HFH_A_TC1) begin
        n.rdata = s.ctl1;
      end else if (bus.addr == `HFH_A_TBS) begin
        n.rdata = s.bsup;
      end else if (bus.addr == `HFH_A_TC2) begin
        n.rdata = s.ctl2;
      end else if (bus.addr == `HFH_A_TXWM) begin
        n.rdata = s.twm;
      end else if (bus.addr == `HFH_A_TXRT) begin
        n.rdata = trt;
      end else if (bus.addr == `HFH_A_TXLAT) begin
        n.rdata = s.tlat;
        tack = 8'hff;
      end else if (bus.addr == `HFH_A_TXMSK) begin
        n.rdata = s.tmask;
      end else if (bus.addr == `HFH_A_TXSPC) begin
        // Snapshot held in rdata until the next read
        n.rdata = {1'b0, `HFH_FIFO_FULL - s.txn};
      end else begin
        n.rdata = 8'h00;
      end
    end

    if (bus.wr) begin
      if (bus.addr == `HFH_A_RXLAT) begin
        rclr = bus.wdata;
      end else if (bus.addr == `HFH_A_RXMSK) begin
        n.rmask = bus.wdata;
      end else if (bus.addr == `HFH_A_RXWM) begin
        n.rwm = bus.wdata;
      end else if (bus.addr == `HFH_A_TC1) begin
        n.ctl1 = bus.wdata;
      end else if (bus.addr == `HFH_A_TBS) begin
        n.bsup = bus.wdata;
      end else if (bus.addr == `HFH_A_TC2) begin
        n.ctl2 = bus.wdata;
      end else if (bus.addr == `HFH_A_TXWM) begin
        n.twm = bus.wdata;
      end else if (bus.addr == `HFH_A_TXLAT) begin
        tclr = bus.wdata;
      end else if (bus.addr == `HFH_A_TXMSK) begin
        n.tmask = bus.wdata;
      end else if (bus.addr == `HFH_A_TXFIFO) begin
        // Writes into a full FIFO are dropped
        tpush = s.txn != `HFH_FIFO_FULL;
      end
    end

    // Receive side; a full FIFO that is popped this cycle still takes the byte
    if (rx_valid) begin
      if (s.rxdrop) begin
        n.rxdrop = ~rx_last;
      end else if (s.rxn == `HFH_FIFO_FULL && !pop) begin
        ovr = 1'b1;
        n.rxdrop = ~rx_last;
        rev[`HFH_RX_OVR] = 1'b1;
      end else begin
        push = 1'b1;
        n.rxm[s.rxw] = {rx_last, rx_byte};
        n.rxw = s.rxw + 6'h01;
        rev[`HFH_RX_MEND] = rx_last;
      end
    end
    if (ovr) begin
      n.rxw = 6'h00;
      n.rxr = 6'h00;
      n.rxn = 7'h00;
    end else begin
      if (pop) begin
        n.rxr = s.rxr + 6'h01;
      end
      n.rxn = s.rxn + {6'h00, push} - {6'h00, pop};
    end

    // Transmit side; end marker taken from control and dropped once used
    if (tpush) begin
      n.txm[s.txw] = {s.ctl1[`HFH_TC1_EOM], bus.wdata};
      n.txw = s.txw + 6'h01;
      n.ctl1[`HFH_TC1_EOM] = 1'b0;
    end
    if (s.txv && tx_ready) begin
      tev[`HFH_TX_MEND] = s.txl;
      tev[`HFH_TX_UDR] = ~s.txl & (s.txn == 7'h00);
    end
    if (!s.txv || tx_ready) begin
      tpop = s.txn != 7'h00;
      n.txv = tpop;
      if (tpop) begin
        n.txb = s.txm[s.txr][7:0];
        n.txl = s.txm[s.txr][8];
        n.txr = s.txr + 6'h01;
      end
    end
    n.txn = s.txn + {6'h00, tpush} - {6'h00, tpop};
    if (n.ctl1[`HFH_TC1_RST]) begin
      n.txn = 7'h00;
      n.txw = 6'h00;
      n.txr = 6'h00;
      n.txv = 1'b0;
      n.ctl1[`HFH_TC1_RST] = 1'b0;
    end

    // Watermark latched bits fire on the rising edge of their condition; set beats clear
    rev[`HFH_RX_HWM] = rrt[`HFH_RX_HWM] & ~s.rrtq[`HFH_RX_HWM];
    tev[`HFH_TX_LWM] = trt[`HFH_TX_LWM] & ~s.trtq[`HFH_TX_LWM];
    n.rrtq  = rrt;
    n.trtq  = trt;
    n.rlat  = (s.rlat & ~rclr) | rev;
    n.tlat  = (s.tlat & ~tclr) | tev;
    n.runrd = (s.runrd & ~rack) | rev;
    n.tunrd = (s.tunrd & ~tack) | tev;
    n.irq_n = ~|{n.runrd & n.rmask, n.tunrd & n.tmask};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s       <= '0;
      s.irq_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign bus.rdata        = s.rdata;
  assign bus.rvalid       = s.rvalid;
  assign bus.irq_out_n    = s.irq_n;
  assign tx_valid         = s.txv;
  assign tx_byte          = s.txb;
  assign tx_last          = s.txl;
  assign tx_hdlc_ctrl_two = s.ctl2;
  assign tx_bit_suppress  = s.bsup;
endmodule
`default_nettype wire

/* File: logic/hfh_host.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`include "hfh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hfh_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  hfh_if.host              bus,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic        irq
);
  hfh_pkg::hfh_host_type s;
  hfh_pkg::hfh_host_type n;

  always_comb begin
    logic       gtx;
    logic       grx;
    logic [2:0] ev;
    logic [2:0] clr;
    n     = s;
    gtx   = 1'b0;
    grx   = 1'b0;
    ev    = 3'h0;
    clr   = 3'h0;
    n.lwr = 1'b0;
    n.lrd = 1'b0;
    if (awvalid && s.awready) begin
      n.awa = awaddr[4:0];
      n.awv = 1'b1;
    end
    if (wvalid && s.wready) begin
      n.wd = wdata;
      n.wv = 1'b1;
    end
    if (bready && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    // Byte strobes ignored: every register is written as a whole word
    if (s.awv && s.wv && !s.bvalid) begin
      n.awv    = 1'b0;
      n.wv     = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `HFH_RESP_OKAY;
      if (s.awa == `HFH_R_CTRL) begin
        gtx = s.wd[0];
        grx = s.wd[1];
        if (s.wd[2]) begin
          n.bwp = 6'h00;
        end
      end else if (s.awa == `HFH_R_TXCFG) begin
        n.cfg = s.wd;
      end else if (s.awa == `HFH_R_TXLEN) begin
        n.len = s.wd[6:0];
      end else if (s.awa == `HFH_R_TXDATA) begin
        n.buff[s.bwp] = s.wd[7:0];
        n.bwp = s.bwp + 6'h01;
      end else if (s.awa == `HFH_R_IST) begin
        clr = s.wd[2:0];
      end else if (s.awa == `HFH_R_IMSK) begin
        n.imsk = s.wd[2:0];
      end else begin
        n.bresp = `HFH_RESP_SLVERR;
      end
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `HFH_RESP_OKAY;
      if (araddr[4:0] == `HFH_R_CTRL) begin
        n.rdata = {16'h0000, s.rxcnt, 7'h00, s.st != hfh_pkg::HFH_IDLE};
      end else if (araddr[4:0] == `HFH_R_TXCFG) begin
        n.rdata = s.cfg;
      end else if (araddr[4:0] == `HFH_R_TXLEN) begin
        n.rdata = {25'h0000000, s.len};
      end else if (araddr[4:0] == `HFH_R_TXDATA) begin
        n.rdata = {26'h0000000, s.bwp};
      end else if (araddr[4:0] == `HFH_R_RXDATA) begin
        n.rdata = {8'h00, s.tst, s.rxst, s.rxbyte};
      end else if (araddr[4:0] == `HFH_R_IST) begin
        n.rdata = {29'h00000000, s.ist};
      end else if (araddr[4:0] == `HFH_R_IMSK) begin
        n.rdata = {29'h00000000, s.imsk};
      end else begin
        n.rdata = 32'h00000000;
        n.rresp = `HFH_RESP_SLVERR;
      end
    end
    n.awready = ~n.awv;
    n.wready  = ~n.wv;
    n.arready = ~n.rvalid;

    case (s.st)
      hfh_pkg::HFH_IDLE: begin
        if (gtx && s.len != 7'h00) begin
          n.st  = hfh_pkg::HFH_CFG;
          n.sub = 3'h0;
          n.idx = 7'h00;
        end else if (grx) begin
          n.st = hfh_pkg::HFH_RCNT;
        end
      end
      hfh_pkg::HFH_CFG: begin
        // Setup writes first, transmit path reset last
        n.lwr = 1'b1;
        n.sub = s.sub + 3'h1;
        case (s.sub)
          3'h0: begin
            n.laddr = `HFH_A_TC1;
            n.lwd   = s.cfg[7:0] & 8'hdb;
          end
          3'h1: begin
            n.laddr = `HFH_A_TBS;
            n.lwd   = s.cfg[15:8];
          end
          3'h2: begin
            n.laddr = `HFH_A_TC2;
            n.lwd   = s.cfg[23:16];
          end
          3'h3: begin
            n.laddr = `HFH_A_TXWM;
            n.lwd   = s.cfg[31:24];
          end
          default: begin
            n.laddr = `HFH_A_TC1;
            n.lwd   = (s.cfg[7:0] & 8'hdb) | 8'h20;
            n.st    = hfh_pkg::HFH_TMASK;
          end
        endcase
      end
      hfh_pkg::HFH_TMASK: begin
        n.lwr   = 1'b1;
        n.laddr = `HFH_A_TXMSK;
        n.lwd   = 8'h01;
        n.st    = hfh_pkg::HFH_TSPC;
      end
      hfh_pkg::HFH_TSPC: begin
        n.lrd   = 1'b1;
        n.laddr = `HFH_A_TXSPC;
        n.st    = hfh_pkg::HFH_TSPW;
      end
      hfh_pkg::HFH_TSPW: begin
        if (bus.rvalid) begin
          n.navail = bus.rdata[6:0];
          n.sub    = 3'h0;
          n.st     = hfh_pkg::HFH_TPUSH;
        end
      end
      hfh_pkg::HFH_TPUSH: begin
        if (s.idx == s.len) begin
          n.st = hfh_pkg::HFH_TWAIT;
        end else if (s.navail == 7'h00) begin
          n.st = hfh_pkg::HFH_TSPC;
        end else if (s.idx == s.len - 7'h01 && s.sub == 3'h0) begin
          n.lwr   = 1'b1;
          n.laddr = `HFH_A_TC1;
          n.lwd   = (s.cfg[7:0] & 8'hdb) | 8'h04;
          n.sub   = 3'h1;
        end else begin
          n.lwr    = 1'b1;
          n.laddr  = `HFH_A_TXFIFO;
          n.lwd    = s.buff[s.idx[5:0]];
          n.idx    = s.idx + 7'h01;
          n.navail = s.navail - 7'h01;
        end
      end
      hfh_pkg::HFH_TWAIT: begin
        if (!bus.irq_out_n) begin
          n.lrd   = 1'b1;
          n.laddr = `HFH_A_TXLAT;
          n.st    = hfh_pkg::HFH_TLATW;
        end
      end
      hfh_pkg::HFH_TLATW: begin
        if (bus.rvalid) begin
          n.tst   = bus.rdata;
          n.lwr   = 1'b1;
          n.laddr = `HFH_A_TXLAT;
          n.lwd   = bus.rdata;
          n.st    = hfh_pkg::HFH_TDEC;
        end
      end
      hfh_pkg::HFH_TDEC: begin
        if (s.tst[`HFH_TX_UDR]) begin
          ev[`HFH_EV_RESEND] = 1'b1;
          n.st  = hfh_pkg::HFH_CFG;
          n.sub = 3'h0;
          n.idx = 7'h00;
        end else begin
          n.lwr   = 1'b1;
          n.laddr = `HFH_A_TXMSK;
          n.lwd   = 8'h00;
          ev[`HFH_EV_TXDONE] = 1'b1;
          n.st = hfh_pkg::HFH_IDLE;
        end
      end
      hfh_pkg::HFH_RCNT: begin
        n.lrd   = 1'b1;
        n.laddr = `HFH_A_RXCNT;
        n.st    = hfh_pkg::HFH_RCNTW;
      end
      hfh_pkg::HFH_RCNTW: begin
        if (bus.rvalid) begin
          n.rxcnt  = bus.rdata;
          n.rxleft = bus.rdata[6:0];
          n.st     = hfh_pkg::HFH_RBYTE;
        end
      end
      hfh_pkg::HFH_RBYTE: begin
        if (s.rxleft != 7'h00) begin
          n.lrd   = 1'b1;
          n.laddr = `HFH_A_RXFIFO;
          n.st    = hfh_pkg::HFH_RBYW;
        end else if (s.rxcnt[7]) begin
          ev[`HFH_EV_RXDONE] = 1'b1;
          n.st = hfh_pkg::HFH_IDLE;
        end else begin
          n.lrd   = 1'b1;
          n.laddr = `HFH_A_RXLAT;
          n.st    = hfh_pkg::HFH_RSTW;
        end
      end
      hfh_pkg::HFH_RBYW: begin
        if (bus.rvalid) begin
          n.rxbyte = bus.rdata;
          n.rxleft = s.rxleft - 7'h01;
          n.st     = hfh_pkg::HFH_RBYTE;
        end
      end
      hfh_pkg::HFH_RSTW: begin
        if (bus.rvalid) begin
          n.rxst  = bus.rdata;
          n.lwr   = 1'b1;
          n.laddr = `HFH_A_RXLAT;
          n.lwd   = bus.rdata;
          ev[`HFH_EV_RXDONE] = 1'b1;
          n.st = hfh_pkg::HFH_IDLE;
        end
      end
      default: begin
        n.st = hfh_pkg::HFH_IDLE;
      end
    endcase
    n.ist = (s.ist & ~clr) | ev;
    n.irq = |(n.ist & n.imsk);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.addr  = s.laddr;
  assign bus.wr    = s.lwr;
  assign bus.rd    = s.lrd;
  assign bus.wdata = s.lwd;
  assign awready   = s.awready;
  assign wready    = s.wready;
  assign bresp     = s.bresp;
  assign bvalid    = s.bvalid;
  assign arready   = s.arready;
  assign rdata     = s.rdata;
  assign rresp     = s.rresp;
  assign rvalid    = s.rvalid;
  assign irq       = s.irq;
endmodule
`default_nettype wire

/* File: test/hfh_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hfh_defines.svh"
module hfh_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic lat_rd;
  assign lat_rd = rd && (addr == `HFH_A_RXLAT || addr == `HFH_A_TXLAT);
  sequence read_s;
    rd ##1 rvalid;
  endsequence
  strobe_excl_a: assert property (!(rd && wr))
    else $error("read and write strobes together");
  read_answer_a: assert property (rd |-> read_s)
    else $error("read not answered next cycle");
  answer_cause_a: assert property (rvalid |-> $past(rd))
    else $error("read answer without a read");
  write_silent_a: assert property (wr |=> !rvalid)
    else $error("write produced a read answer");
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved between reads");
  space_range_a: assert property (rvalid && $past(addr) == `HFH_A_TXSPC |-> rdata <= 8'h40)
    else $error("free space above fifo size");
  count_range_a: assert property (rvalid && $past(addr) == `HFH_A_RXCNT |-> rdata[6:0] <= 7'h40)
    else $error("receive count above fifo size");
  irq_release_a: assert property ($rose(irq_out_n) |-> $past(lat_rd) || $past(lat_rd, 2))
    else $error("interrupt released without status read");
endmodule
`default_nettype wire

/* File: test/hdlc_fifo_host_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hfh_defines.svh"
module hdlc_fifo_host_status_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        rx_valid = 1'b0, rx_last = 1'b0, tx_ready = 1'b0;
  logic [7:0]  rx_byte = 8'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_valid, tx_last;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [7:0]  tx_byte, tx_ctrl_two, tx_supp;
  logic [8:0]  txq[$];
  int          failures = 0;
  int          total_checks = 0;
  always #50 aclk = ~aclk;
  hfh_if hfh_if_inst ();
  hfh_dev hfh_dev_inst (.aclk(aclk), .aresetn(aresetn), .bus(hfh_if_inst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_last(rx_last), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_hdlc_ctrl_two(tx_ctrl_two), .tx_bit_suppress(tx_supp));
  hfh_host hfh_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(hfh_if_inst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
  hfh_chk hfh_chk_inst (.aclk(aclk), .aresetn(aresetn), .addr(hfh_if_inst.addr), .wr(hfh_if_inst.wr),
    .rd(hfh_if_inst.rd), .wdata(hfh_if_inst.wdata), .rdata(hfh_if_inst.rdata),
    .rvalid(hfh_if_inst.rvalid), .irq_out_n(hfh_if_inst.irq_out_n));
  always @(posedge aclk) if (tx_valid === 1'b1 && tx_ready) txq.push_back({tx_last, tx_byte});
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("failures %0d checks %0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    awaddr <= {27'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 500);
    resp = bresp;
    chk("write answer", 32'h1, {31'h0, bvalid});
    bready <= 1'b0;
    // Idle edge so the next call never rewrites bready in this step
    @(posedge aclk);
  endtask
  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    araddr <= {27'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 500);
    d = rdata;
    resp = rresp;
    chk("read answer", 32'h1, {31'h0, rvalid});
    rready <= 1'b0;
    // Idle edge so the next call never rewrites rready in this step
    @(posedge aclk);
  endtask
  task automatic wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n == 3000) begin
      failures++;
      $display("BAD irq expected 1 seen %b", irq);
    end
  endtask
  task automatic rxs(input int n, input logic last, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_byte <= b + 8'(i);
      rx_last <= last && (i == n - 1);
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  task automatic rxrun(input logic [7:0] cnt, input logic [7:0] lastb, output logic [7:0] st);
    axw(`HFH_R_IMSK, 32'h4, r);
    axw(`HFH_R_CTRL, 32'h2, r);
    wirq();
    axr(`HFH_R_CTRL, v, r);
    chk("rx count", {24'h0, cnt}, {24'h0, v[15:8]});
    axr(`HFH_R_RXDATA, v, r);
    chk("rx byte", {24'h0, lastb}, {24'h0, v[7:0]});
    st = v[15:8];
    axw(`HFH_R_IST, 32'h4, r);
  endtask
  task automatic t_axi;
    axr(5'h1c, v, r);
    chk("bad read resp", `HFH_RESP_SLVERR, r);
    axw(5'h1c, 32'h0, r);
    chk("bad write resp", `HFH_RESP_SLVERR, r);
  endtask
  // Engine stalls until all bytes are queued, so no underrun is expected
  task automatic t_tx;
    tx_ready <= 1'b0;
    axw(`HFH_R_TXCFG, 32'h0433_5a00, r);
    axw(`HFH_R_TXLEN, 32'h5, r);
    axw(`HFH_R_CTRL, 32'h4, r);
    for (int i = 0; i < 5; i++) axw(`HFH_R_TXDATA, 32'ha0 + i, r);
    axw(`HFH_R_IMSK, 32'h1, r);
    axw(`HFH_R_CTRL, 32'h1, r);
    repeat (200) @(posedge aclk);
    chk("bit suppress", 32'h5a, {24'h0, tx_supp});
    chk("ctrl two", 32'h33, {24'h0, tx_ctrl_two});
    tx_ready <= 1'b1;
    wirq();
    chk("tx count", 32'h5, txq.size());
    for (int i = 0; i < txq.size(); i++) chk("tx byte", {i == 4, 8'ha0 + 8'(i)}, txq[i]);
    axr(`HFH_R_IST, v, r);
    chk("tx status", 32'h1, v);
    axw(`HFH_R_IMSK, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(`HFH_R_IST, 32'h7, r);
    axw(`HFH_R_IMSK, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // Engine drains faster than the host fills, so the gap before the last byte underruns
  task automatic t_udr;
    txq.delete();
    axw(`HFH_R_IMSK, 32'h2, r);
    tx_ready <= 1'b1;
    axw(`HFH_R_CTRL, 32'h1, r);
    wirq();
    tx_ready <= 1'b0;
    axr(`HFH_R_IST, v, r);
    chk("resend flag", 32'h2, v);
    axw(`HFH_R_IST, 32'h2, r);
    axw(`HFH_R_IMSK, 32'h1, r);
    repeat (50) @(posedge aclk);
    tx_ready <= 1'b1;
    wirq();
    chk("resend count", 32'ha, txq.size());
    chk("resend last", 32'h1a4, {23'h0, txq[9]});
    axr(`HFH_R_IST, v, r);
    chk("resend done", 32'h1, v);
    axw(`HFH_R_IST, 32'h7, r);
    axw(`HFH_R_IMSK, 32'h0, r);
  endtask
  task automatic t_rx;
    logic [7:0] st;
    rxs(3, 1'b1, 8'h10);
    rxrun(8'h03, 8'h12, st);
    chk("rx end flag", 32'h1, {24'h0, st & 8'h01});
    rxs(4, 1'b0, 8'h20);
    rxrun(8'h84, 8'h23, st);
    rxs(1, 1'b1, 8'h30);
    rxrun(8'h01, 8'h30, st);
  endtask
  task automatic t_ovr;
    logic [7:0] st;
    rxs(66, 1'b0, 8'h00);
    rxs(2, 1'b1, 8'h50);
    rxs(2, 1'b1, 8'h80);
    rxrun(8'h02, 8'h81, st);
    chk("overrun flag", 32'h20, {24'h0, st & 8'h20});
    rxs(1, 1'b1, 8'h90);
    rxrun(8'h01, 8'h90, st);
    chk("overrun cleared", 32'h0, {24'h0, st & 8'h20});
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_axi();
    t_tx();
    t_udr();
    t_rx();
    t_ovr();
    summarize();
  end
  initial begin
    #(60000 * 100);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
